// File: rtl/wdsh_map.vh
// Constants of the watchdog service handshake block: register offsets,
// field positions, reset values and slow-oscillator cycle windows.
// Assumes an APB slave with 32-bit data, one aligned word per register.
`ifndef WDSH_MAP_VH
`define WDSH_MAP_VH

// ============================================================
// Register byte offsets
`define WDSH_OFS_CTRL      8'h00
`define WDSH_OFS_KICK      8'h04
`define WDSH_OFS_COUNT     8'h08
`define WDSH_OFS_WARN_LIM  8'h0c
`define WDSH_OFS_UPPER_LIM 8'h10
`define WDSH_OFS_ACTION    8'h14
`define WDSH_OFS_STATUS    8'h18

// ============================================================
// Field positions
`define WDSH_CTRL_EN       0
`define WDSH_KICK_BIT      0
`define WDSH_ACT_WARN_LSB  0
`define WDSH_ACT_UPPER_LSB 2
`define WDSH_ST_WARN       0
`define WDSH_ST_UPPER      1
`define WDSH_ST_HS_OPEN    2

// ============================================================
// Response encodings of a two-bit action field
`define WDSH_ACT_NONE      2'h0
`define WDSH_ACT_IRQ       2'h1
`define WDSH_ACT_FAULT     2'h2
`define WDSH_ACT_RESET     2'h3

// ============================================================
// Reset values
`define WDSH_RST_CTRL      1'h0
`define WDSH_RST_ACTION    4'h0
`define WDSH_RST_WARN_LIM  16'h8000
`define WDSH_RST_UPPER_LIM 16'hffff

// ============================================================
// Slow-oscillator cycle windows
`define WDSH_LATE_CYCLES   3'h4
`define WDSH_WAKE_CYCLES   2'h2

`endif

// File: rtl/wdsh_tick.v
// Rising-edge detector that turns the slow oscillator level into a
// one-cycle tick. Assumes the oscillator input is synchronous to the clock.
`timescale 1ns/1ps

module wdsh_tick
(
  // Clock and reset
  input  wire i_clk,
  input  wire i_srst,
  // Oscillator level and tick
  input  wire i_level,
  output reg  o_tick
);

  reg level_q;

  // ============================================================
  // Edge detect
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      level_q <= 1'b0;
      o_tick  <= 1'b0;
    end
    else
    begin
      level_q <= i_level;
      o_tick  <= i_level & ~level_q;
    end
  end

endmodule

// File: rtl/wdsh_thresh.v
// Threshold comparator: one-cycle hit when the count first equals the limit.
// Assumes count and limit are stable registers in the same clock domain.
`timescale 1ns/1ps

module wdsh_thresh
#(
  parameter CW = 16
)
(
  // Clock and reset
  input  wire          i_clk,
  input  wire          i_srst,
  // Compare inputs
  input  wire          i_arm,
  input  wire [CW-1:0] i_count,
  input  wire [CW-1:0] i_limit,
  // Hit pulse
  output reg           o_hit
);

  reg eq_q;

  // ============================================================
  // Match and rising-edge of the match
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      eq_q  <= 1'b0;
      o_hit <= 1'b0;
    end
    else
    begin
      eq_q  <= i_arm & (i_count == i_limit);
      o_hit <= i_arm & (i_count == i_limit) & ~eq_q;
    end
  end

endmodule

// File: rtl/wdsh_top.v
// Watchdog counter on the slow oscillator with its service handshake,
// including the late-service-before-sleep hazard and its wakeup window.
// Assumes an APB master on I_CLOCK and synchronous sleep/oscillator inputs.
`timescale 1ns/1ps
`include "wdsh_map.vh"

module wdsh_top
#(
  parameter CW = 16
)
(
  // Clock and reset
  input  wire        I_CLOCK,
  input  wire        I_SRST,
  // APB slave
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [7:0]  I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output reg         O_PREADY,
  output reg         O_PSLVERR,
  // Slow oscillator and power state
  input  wire        I_SLOW_INTERNAL_OSC,
  input  wire        I_DEEP_LOW_POWER_STATE,
  // Watchdog responses
  output reg         O_IRQ,
  output reg         O_FAULT,
  output reg         O_RESET_REQ
);

  // ============================================================
  // Declarations
  wire          tick;
  wire          warn_hit;
  wire          upper_hit;
  wire          access;
  wire          wr_fire;
  wire          rd_take;
  wire          addr_ok;
  wire          enter_sleep;
  wire          service_now;
  wire          lost_window;
  wire          kick_write;
  wire          kick_ready;
  reg           enable;
  reg  [3:0]    action;
  reg  [CW-1:0] warn_limit;
  reg  [CW-1:0] upper_limit;
  reg  [CW-1:0] wdog_count_value;
  reg           kick_pending;
  reg  [2:0]    since_service;
  reg           hs_open;
  reg  [1:0]    wake_ticks;
  reg           sleep_q;
  reg           warn_flag;
  reg           upper_flag;
  reg  [31:0]   next_rdata;
  reg           next_irq;
  reg           next_fault;
  reg           next_reset;

  // ============================================================
  // Slow oscillator tick
  wdsh_tick u_tick
  (
    .i_clk   (I_CLOCK),
    .i_srst  (I_SRST),
    .i_level (I_SLOW_INTERNAL_OSC),
    .o_tick  (tick)
  );

  // ============================================================
  // Threshold comparators
  wdsh_thresh #(.CW(CW)) u_warn
  (
    .i_clk   (I_CLOCK),
    .i_srst  (I_SRST),
    .i_arm   (enable),
    .i_count (wdog_count_value),
    .i_limit (warn_limit),
    .o_hit   (warn_hit)
  );

  wdsh_thresh #(.CW(CW)) u_upper
  (
    .i_clk   (I_CLOCK),
    .i_srst  (I_SRST),
    .i_arm   (enable),
    .i_count (wdog_count_value),
    .i_limit (upper_limit),
    .o_hit   (upper_hit)
  );

  // ============================================================
  // APB phase decode: one wait state, write acts at the ready edge
  assign access  = I_PSEL & I_PENABLE;
  assign rd_take = access & ~O_PREADY;
  assign wr_fire = access & O_PREADY & I_PWRITE & ~O_PSLVERR;
  assign addr_ok = (I_PADDR == `WDSH_OFS_CTRL)
                 | (I_PADDR == `WDSH_OFS_KICK)
                 | (I_PADDR == `WDSH_OFS_COUNT)
                 | (I_PADDR == `WDSH_OFS_WARN_LIM)
                 | (I_PADDR == `WDSH_OFS_UPPER_LIM)
                 | (I_PADDR == `WDSH_OFS_ACTION)
                 | (I_PADDR == `WDSH_OFS_STATUS);

  // ============================================================
  // Service path terms
  assign kick_write  = wr_fire & (I_PADDR == `WDSH_OFS_KICK)
                     & I_PWDATA[`WDSH_KICK_BIT];
  assign service_now = tick & kick_pending & enable;
  assign enter_sleep = I_DEEP_LOW_POWER_STATE & ~sleep_q;
  assign lost_window = hs_open & ~sleep_q;
  assign kick_ready  = ~kick_pending & ~hs_open;

  // ============================================================
  // APB answer: ready, error and read data
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= 32'h0;
    end
    else
    begin
      O_PREADY  <= rd_take;
      O_PSLVERR <= rd_take & ~addr_ok;
      if (rd_take)
        O_PRDATA <= next_rdata;
    end
  end

  // ============================================================
  // Read multiplexer; reading the count leaves it running
  always @*
  begin
    next_rdata = 32'h0;
    if (~I_PWRITE)
    begin
      case (I_PADDR)
        `WDSH_OFS_CTRL:
          next_rdata[`WDSH_CTRL_EN] = enable;
        `WDSH_OFS_KICK:
          next_rdata[`WDSH_KICK_BIT] = ~kick_ready;
        `WDSH_OFS_COUNT:
          next_rdata[CW-1:0] = wdog_count_value;
        `WDSH_OFS_WARN_LIM:
          next_rdata[CW-1:0] = warn_limit;
        `WDSH_OFS_UPPER_LIM:
          next_rdata[CW-1:0] = upper_limit;
        `WDSH_OFS_ACTION:
          next_rdata[3:0] = action;
        `WDSH_OFS_STATUS:
        begin
          next_rdata[`WDSH_ST_WARN]    = warn_flag;
          next_rdata[`WDSH_ST_UPPER]   = upper_flag;
          next_rdata[`WDSH_ST_HS_OPEN] = hs_open;
        end
        default:
          next_rdata = 32'h0;
      endcase
    end
  end

  // ============================================================
  // Configuration registers
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      enable      <= `WDSH_RST_CTRL;
      action      <= `WDSH_RST_ACTION;
      warn_limit  <= `WDSH_RST_WARN_LIM;
      upper_limit <= `WDSH_RST_UPPER_LIM;
    end
    else if (wr_fire)
    begin
      case (I_PADDR)
        `WDSH_OFS_CTRL:
          enable <= I_PWDATA[`WDSH_CTRL_EN];
        `WDSH_OFS_WARN_LIM:
          warn_limit <= I_PWDATA[CW-1:0];
        `WDSH_OFS_UPPER_LIM:
          upper_limit <= I_PWDATA[CW-1:0];
        `WDSH_OFS_ACTION:
          action <= I_PWDATA[3:0];
        default:
          enable <= enable;
      endcase
    end
  end

  // ============================================================
  // Kick request: taken unless the wakeup window swallows it
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
      kick_pending <= 1'b0;
    else if (kick_write & ~lost_window)
      kick_pending <= 1'b1;
    else if (service_now)
      kick_pending <= 1'b0;
  end

  // ============================================================
  // Watchdog count: one step per slow cycle, cleared by a service
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
      wdog_count_value <= {CW{1'b0}};
    else if (service_now)
      wdog_count_value <= {CW{1'b0}};
    else if (tick & enable)
      wdog_count_value <= wdog_count_value + 1'b1;
  end

  // ============================================================
  // Slow cycles since the last service, saturating at the late window
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
      since_service <= `WDSH_LATE_CYCLES;
    else if (service_now)
      since_service <= 3'h0;
    else if (tick & (since_service != `WDSH_LATE_CYCLES))
      since_service <= since_service + 3'h1;
  end

  // ============================================================
  // Handshake state across sleep entry and wakeup
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      sleep_q    <= 1'b0;
      hs_open    <= 1'b0;
      wake_ticks <= 2'h0;
    end
    else
    begin
      sleep_q <= I_DEEP_LOW_POWER_STATE;
      if (enter_sleep)
      begin
        wake_ticks <= 2'h0;
        if (service_now | (since_service != `WDSH_LATE_CYCLES))
          hs_open <= 1'b1;
      end
      else if (hs_open & ~sleep_q & tick)
      begin
        if (wake_ticks == `WDSH_WAKE_CYCLES - 2'h1)
        begin
          hs_open    <= 1'b0;
          wake_ticks <= 2'h0;
        end
        else
          wake_ticks <= wake_ticks + 2'h1;
      end
    end
  end

  // ============================================================
  // Sticky threshold flags: hit wins over a write-one-to-clear
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      warn_flag  <= 1'b0;
      upper_flag <= 1'b0;
    end
    else
    begin
      if (warn_hit)
        warn_flag <= 1'b1;
      else if (wr_fire & (I_PADDR == `WDSH_OFS_STATUS)
               & I_PWDATA[`WDSH_ST_WARN])
        warn_flag <= 1'b0;
      if (upper_hit)
        upper_flag <= 1'b1;
      else if (wr_fire & (I_PADDR == `WDSH_OFS_STATUS)
               & I_PWDATA[`WDSH_ST_UPPER])
        upper_flag <= 1'b0;
    end
  end

  // ============================================================
  // Response selection from the action fields
  always @*
  begin
    next_irq   = (warn_flag & (action[1:0] == `WDSH_ACT_IRQ))
               | (upper_flag & (action[3:2] == `WDSH_ACT_IRQ));
    next_fault = (warn_flag & (action[1:0] == `WDSH_ACT_FAULT))
               | (upper_flag & (action[3:2] == `WDSH_ACT_FAULT));
    next_reset = (warn_flag & (action[1:0] == `WDSH_ACT_RESET))
               | (upper_flag & (action[3:2] == `WDSH_ACT_RESET));
  end

  // ============================================================
  // Registered response outputs
  always @(posedge I_CLOCK)
  begin
    if (I_SRST)
    begin
      O_IRQ       <= 1'b0;
      O_FAULT     <= 1'b0;
      O_RESET_REQ <= 1'b0;
    end
    else
    begin
      O_IRQ       <= next_irq;
      O_FAULT     <= next_fault;
      O_RESET_REQ <= next_reset;
    end
  end

endmodule

// File: bench/wdsh_chk.sv
// Port checker for the watchdog service block: bus answer and responses.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module wdsh_chk
(
  // Clock and reset
  input wire I_CLOCK,
  input wire I_SRST,
  // APB
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire O_PREADY,
  input wire O_PSLVERR,
  // Responses
  input wire O_IRQ,
  input wire O_FAULT,
  input wire O_RESET_REQ
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_SRST);

  // ====
  // Bus answer: one wait state, one-cycle ready
  AST_RDY_ONE_WAIT: assert property (I_PSEL && I_PENABLE && !O_PREADY
    |=> O_PREADY) else $error("ready late");
  AST_RDY_PULSE: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held");
  AST_ERR_WITH_RDY: assert property (O_PSLVERR
    |-> O_PREADY && I_PSEL && I_PENABLE) else $error("stray error");
  AST_IDLE_QUIET: assert property (!I_PSEL |=> !O_PREADY [*2])
    else $error("ready without request");
  // ====
  // Responses drop only within three cycles after a completed transfer
  AST_IRQ_FALL: assert property ($fell(O_IRQ) |-> $past(O_PREADY)
    || $past(O_PREADY, 2) || $past(O_PREADY, 3)) else $error("irq fell");
  AST_FAULT_FALL: assert property ($fell(O_FAULT) |-> $past(O_PREADY)
    || $past(O_PREADY, 2) || $past(O_PREADY, 3)) else $error("fault fell");
  AST_RST_FALL: assert property ($fell(O_RESET_REQ)
    |-> $past(O_PREADY, 2) || $past(O_PREADY, 3) || $past(O_PREADY))
    else $error("reset request fell");
  // Main scenarios
  cover property (O_PSLVERR);
  cover property ($rose(O_IRQ));
  cover property ($rose(O_RESET_REQ));
endmodule

bind wdsh_top wdsh_chk wdsh_chk_i
(
  .I_CLOCK     (I_CLOCK),
  .I_SRST      (I_SRST),
  .I_PSEL      (I_PSEL),
  .I_PENABLE   (I_PENABLE),
  .O_PREADY    (O_PREADY),
  .O_PSLVERR   (O_PSLVERR),
  .O_IRQ       (O_IRQ),
  .O_FAULT     (O_FAULT),
  .O_RESET_REQ (O_RESET_REQ)
);

// File: bench/wdsh_top_bench.sv
// Self-checking bench for the watchdog service handshake block.
// Assumes the bench drives APB, slow oscillator and power state itself.
`timescale 1ns/1ps
`include "wdsh_map.vh"

module wdsh_top_bench;
  // ====
  // Stimulus and observed signals
  reg         clk    = 1'b0;
  reg         srst   = 1'b1;
  reg         psel   = 1'b0;
  reg         pen    = 1'b0;
  reg         pwr    = 1'b0;
  reg  [7:0]  paddr  = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         osc    = 1'b0;
  reg         sleep  = 1'b0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        irq;
  wire        fault;
  wire        rreq;
  reg  [31:0] q;
  reg         err;
  integer     n_fail      = 0;
  integer     comparisons = 0;
  integer     k;

  // 125 MHz clock
  always #4 clk = ~clk;

  wdsh_top wdsh_top_i
  (
    .I_CLOCK                (clk),
    .I_SRST                 (srst),
    .I_PSEL                 (psel),
    .I_PENABLE              (pen),
    .I_PWRITE               (pwr),
    .I_PADDR                (paddr),
    .I_PWDATA               (pwdata),
    .O_PRDATA               (prdata),
    .O_PREADY               (pready),
    .O_PSLVERR              (pslverr),
    .I_SLOW_INTERNAL_OSC    (osc),
    .I_DEEP_LOW_POWER_STATE (sleep),
    .O_IRQ                  (irq),
    .O_FAULT                (fault),
    .O_RESET_REQ            (rreq)
  );

  // ====
  // Compare, bus and oscillator tasks
  task chk(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %0t: got %h, expected %h", $time, got, exp);
    end
  end
  endtask

  // One APB transfer, held until ready is sampled high
  task xfer(input w, input [7:0] ad, input [31:0] d);
    integer n;
  begin
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk({31'h0, pready}, 32'h1);
    q   = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  end
  endtask

  task wr(input [7:0] ad, input [31:0] d);
  begin
    xfer(1'b1, ad, d);
  end
  endtask

  task rdc(input [7:0] ad, input [31:0] exp);
  begin
    xfer(1'b0, ad, 32'h0);
    chk(q, exp);
  end
  endtask

  // Slow oscillator cycles of eight clocks each
  task slow(input integer n);
  begin
    repeat (n)
    begin
      osc <= 1'b1;
      repeat (4) @(posedge clk);
      osc <= 1'b0;
      repeat (4) @(posedge clk);
    end
  end
  endtask

  // Poll the kick bit until ready, then service
  task kick;
    integer n;
  begin
    n = 0;
    xfer(1'b0, `WDSH_OFS_KICK, 32'h0);
    while (q[0] !== 1'b0 && n < 8)
    begin
      slow(1);
      xfer(1'b0, `WDSH_OFS_KICK, 32'h0);
      n = n + 1;
    end
    chk(q, 32'h0);
    wr(`WDSH_OFS_KICK, 32'h1);
  end
  endtask

  task stop_test;
  begin
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  // ====
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    chk({29'h0, rreq, fault, irq}, 32'h0);
    rdc(`WDSH_OFS_CTRL, 32'h0);
    rdc(`WDSH_OFS_ACTION, 32'h0);
    rdc(`WDSH_OFS_WARN_LIM, 32'h8000);
    rdc(`WDSH_OFS_UPPER_LIM, 32'hffff);
    rdc(`WDSH_OFS_KICK, 32'h0);
    rdc(8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(`WDSH_OFS_CTRL, 32'h1);
    slow(3);
    rdc(`WDSH_OFS_COUNT, 32'h3);
    rdc(`WDSH_OFS_COUNT, 32'h3);
    kick;
    rdc(`WDSH_OFS_KICK, 32'h1);
    slow(1);
    rdc(`WDSH_OFS_KICK, 32'h0);
    rdc(`WDSH_OFS_COUNT, 32'h0);
    // Late service just before sleep entry
    slow(2);
    kick;
    slow(1);
    sleep <= 1'b1;
    slow(2);
    rdc(`WDSH_OFS_COUNT, 32'h2);
    rdc(`WDSH_OFS_STATUS, 32'h4);
    // Early service after wakeup is lost
    sleep <= 1'b0;
    wr(`WDSH_OFS_KICK, 32'h1);
    rdc(`WDSH_OFS_KICK, 32'h1);
    slow(1);
    rdc(`WDSH_OFS_COUNT, 32'h3);
    slow(1);
    rdc(`WDSH_OFS_STATUS, 32'h0);
    slow(2);
    kick;
    slow(1);
    rdc(`WDSH_OFS_COUNT, 32'h0);
    // Every active response code (IRQ, FAULT, RESET) on the warning threshold
    wr(`WDSH_OFS_WARN_LIM, 32'h2);
    for (k = 1; k < 4; k = k + 1)
    begin
      wr(`WDSH_OFS_ACTION, k);
      kick;
      slow(3);
      repeat (4) @(posedge clk);
      chk({29'h0, rreq, fault, irq}, 32'h1 << (k - 1));
      rdc(`WDSH_OFS_STATUS, 32'h1);
      wr(`WDSH_OFS_STATUS, 32'h1);
      repeat (4) @(posedge clk);
      chk({29'h0, rreq, fault, irq}, 32'h0);
    end
    // Upper threshold asks for reset, warning action left at none
    wr(`WDSH_OFS_ACTION, 32'hc);
    wr(`WDSH_OFS_UPPER_LIM, 32'h3);
    kick;
    slow(4);
    repeat (4) @(posedge clk);
    chk({29'h0, rreq, fault, irq}, 32'h4);
    rdc(`WDSH_OFS_STATUS, 32'h3);
    rdc(`WDSH_OFS_COUNT, 32'h3);
    wr(`WDSH_OFS_STATUS, 32'h3);
    repeat (4) @(posedge clk);
    chk({29'h0, rreq, fault, irq}, 32'h0);
    rdc(`WDSH_OFS_STATUS, 32'h0);
    stop_test;
  end

  // Hang guard
  initial
  begin
    #50000;
    n_fail = n_fail + 1;
    $display("CHECK FAILED %0t: timeout", $time);
    stop_test;
  end
endmodule
